// *** rtl/eeh_ctrl.sv ***
// Host controller driving a two-wire serial memory, plus its write buffer.
// Assumes open-drain SDA resolved outside; SCL is driven push-pull here.
`timescale 1ns/10ps

// ==========================================================
// Write data buffer
// ==========================================================
module eeh_fifo #(
   parameter int WIDTH = 8,                 // Word width
   parameter int DEPTH = 16                 // Entries, power of two
) (
   input  wire logic             clock,     // System clock
   input  wire logic             sys_rst,   // Synchronous reset
   input  wire logic             in_valid,  // Word offered
   input  wire logic [WIDTH-1:0] in_data,   // Word in
   output logic                  in_ready,  // Room for a word
   output logic                  out_valid, // Word available
   input  wire logic             out_ready, // Consumer takes the word
   output logic      [WIDTH-1:0] out_data   // Oldest word
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("eeh_fifo depth must be a power of two");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];         // Storage
   logic [AW-1:0]    wp_q, wp_d;            // Write pointer
   logic [AW-1:0]    rp_q, rp_d;            // Read pointer
   logic [AW:0]      cnt_q, cnt_d;          // Fill level
   logic             room_q, room_d;        // Registered room, drives in_ready
   logic             push, pop;             // Accepted moves

   assign push      = in_valid && room_q;
   assign pop       = out_ready && (cnt_q != '0);
   assign in_ready  = room_q;
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];

   // Pointer and level arithmetic; pointers wrap naturally
   always_comb begin
      wp_d   = wp_q + AW'(push);
      rp_d   = rp_q + AW'(pop);
      cnt_d  = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      room_d = (cnt_d != (AW + 1)'(DEPTH));
   end

   // Pointer, level and room registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wp_q   <= '0;
         rp_q   <= '0;
         cnt_q  <= '0;
         room_q <= 1'b1;
      end else begin
         wp_q   <= wp_d;
         rp_q   <= rp_d;
         cnt_q  <= cnt_d;
         room_q <= room_d;
      end
   end

   // Storage has no reset; contents are only read once written
   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end
endmodule

// ==========================================================
// Bus controller
// ==========================================================
module eeh_ctrl #(
   parameter int PROG_CYC = eeh_pkg::PROG_CYC, // Poll give-up time in cycles
   parameter int QTR_CYC  = eeh_pkg::QTR_CYC   // Cycles per quarter bit
) (
   input  wire logic        clock,          // System clock, 100 MHz
   input  wire logic        sys_rst,        // Synchronous reset, active high
   input  wire logic        cmd_valid,      // Command offered
   output logic             cmd_ready,      // Idle, command taken
   input  wire logic [1:0]  cmd_op,         // Command kind
   input  wire logic [2:0]  cmd_chip,       // Chip select straps of target
   input  wire logic [14:0] cmd_addr,       // Word address
   input  wire logic [5:0]  cmd_len,        // Byte count minus one
   input  wire logic        wr_valid,       // Write byte offered
   input  wire logic [7:0]  wr_data,        // Write byte
   output logic             wr_ready,       // Buffer has room
   output logic             rd_valid,       // Read byte pulse
   output logic [7:0]       rd_data,        // Read byte
   output logic             done,           // Command finished pulse
   output logic             err,            // Last command saw a no-ack
   output logic             scl,            // Serial clock out
   output logic             sda_out,        // SDA drive value, always low
   output logic             sda_oe,         // SDA pulled low when high
   input  wire logic        sda_in          // SDA level from the wire
);
   // Quarters under four cycles would outrun the SDA synchroniser
   if (PROG_CYC < 1 || PROG_CYC >= 2 ** 24 || QTR_CYC < 4 ||
       QTR_CYC >= 2 ** eeh_pkg::QCNT_W) begin : g_chk
      $error("eeh_ctrl timing parameter out of range");
   end

   typedef enum {
      ST_IDLE, ST_START, ST_DEV, ST_AHI, ST_ALO, ST_WWAIT, ST_WDATA, ST_RSTART,
      ST_RDEV, ST_RDATA, ST_STOP, ST_PSTART, ST_PDEV, ST_CLK9
   } eeh_state_t;

   eeh_state_t                  state_q, state_d;   // Sequencer state
   eeh_pkg::eeh_op_t            op_q, op_d;         // Command in progress
   eeh_pkg::eeh_cls_t           cls;                // Symbol of this state
   logic [2:0]                  chip_q, chip_d;     // Target straps
   logic [14:0]                 addr_q, addr_d;     // Target word address
   logic [5:0]                  left_q, left_d;     // Bytes left minus one
   logic [7:0]                  shreg_q, shreg_d;   // Byte shifter
   logic [eeh_pkg::QCNT_W-1:0]  qcnt_q, qcnt_d;     // Cycles in quarter
   logic [1:0]                  ph_q, ph_d;         // Quarter of the bit
   logic [3:0]                  bit_q, bit_d;       // Bit of the symbol
   logic                        ack_q, ack_d;       // Device pulled SDA low
   logic                        pend_q, pend_d;     // Program cycle to poll
   logic [23:0]                 poll_q, poll_d;     // Polling time
   logic                        tick, last, sym_done;
   logic                        scl_d, sda_oe_d, cmd_ready_d, done_d, err_q, err_d;
   logic                        rdv_d, fifo_valid, fifo_pop;
   logic [7:0]                  fifo_data, rd_d;
   logic                        sda_m_q, sda_s_q;   // SDA synchroniser

   eeh_fifo #(.WIDTH(eeh_pkg::DATA_W), .DEPTH(eeh_pkg::FIFO_DEPTH)) u_fifo (
      .clock     (clock),
      .sys_rst   (sys_rst),
      .in_valid  (wr_valid),
      .in_data   (wr_data),
      .in_ready  (wr_ready),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // Symbol kind of each state; idle and wait states hold the bus
   always_comb begin
      unique case (state_q)
         ST_START, ST_RSTART, ST_PSTART:                 cls = eeh_pkg::CL_START;
         ST_STOP:                                        cls = eeh_pkg::CL_STOP;
         ST_DEV, ST_AHI, ST_ALO, ST_WDATA, ST_RDEV, ST_PDEV: cls = eeh_pkg::CL_TX;
         ST_RDATA:                                       cls = eeh_pkg::CL_RX;
         ST_CLK9:                                        cls = eeh_pkg::CL_CLK;
         ST_IDLE, ST_WWAIT:                              cls = eeh_pkg::CL_NONE;
      endcase
   end

   assign tick = (qcnt_q == eeh_pkg::QCNT_W'(QTR_CYC - 1));
   assign last = (cls == eeh_pkg::CL_START || cls == eeh_pkg::CL_STOP) ? (bit_q == 4'h0)
                                                                      : (bit_q == eeh_pkg::BIT_LAST);
   assign sym_done = tick && (ph_q == 2'h3) && last;

   // Pin shapes per quarter: clock high in the middle two quarters, in the last three for stop
   always_comb begin
      scl_d    = 1'b0;
      sda_oe_d = 1'b0;
      unique case (cls)
         eeh_pkg::CL_NONE: scl_d = (state_q == ST_IDLE);
         eeh_pkg::CL_START: begin
            scl_d    = (ph_q == 2'h1) || (ph_q == 2'h2);
            sda_oe_d = ph_q[1];                          // Falls under high clock
         end
         eeh_pkg::CL_STOP: begin
            scl_d    = (ph_q != 2'h0);
            sda_oe_d = !ph_q[1];                         // Rises under high clock
         end
         eeh_pkg::CL_TX: begin
            scl_d    = (ph_q == 2'h1) || (ph_q == 2'h2);
            // MSB first, released for the ninth clock
            sda_oe_d = (bit_q != eeh_pkg::BIT_LAST) && !shreg_q[7];
         end
         eeh_pkg::CL_RX: begin
            scl_d    = (ph_q == 2'h1) || (ph_q == 2'h2);
            // Ack all but the final byte, which gets a no-ack
            sda_oe_d = (bit_q == eeh_pkg::BIT_LAST) && (left_q != 6'h0);
         end
         eeh_pkg::CL_CLK: scl_d = (ph_q == 2'h1) || (ph_q == 2'h2);  // SDA free
         default: scl_d = 1'b0;
      endcase
   end

   // Bit timing, sampling and the command sequencer
   always_comb begin
      state_d = state_q;
      op_d    = op_q;
      chip_d  = chip_q;
      addr_d  = addr_q;
      left_d  = left_q;
      shreg_d = shreg_q;
      qcnt_d  = qcnt_q;
      ph_d    = ph_q;
      bit_d   = bit_q;
      ack_d   = ack_q;
      pend_d  = pend_q;
      err_d   = err_q;
      done_d  = 1'b0;
      rdv_d   = 1'b0;
      rd_d    = rd_data;
      fifo_pop = 1'b0;
      // Poll time runs only while polling, saturating at the top
      poll_d = (state_q == ST_PSTART || state_q == ST_PDEV) ? poll_q + 24'(poll_q != '1) : '0;
      // Quarter and bit counters; SDA is sampled late in the high clock
      if (cls != eeh_pkg::CL_NONE) begin
         if (tick) begin
            qcnt_d = '0;
            ph_d   = ph_q + 2'h1;
            if (ph_q == 2'h2 && cls == eeh_pkg::CL_TX && bit_q == eeh_pkg::BIT_LAST) begin
               ack_d = !sda_s_q;                         // Device answer
            end
            if (ph_q == 2'h2 && cls == eeh_pkg::CL_RX && bit_q != eeh_pkg::BIT_LAST) begin
               shreg_d = {shreg_q[6:0], sda_s_q};
            end
            if (ph_q == 2'h3) begin
               bit_d = last ? 4'h0 : bit_q + 4'h1;
               if (cls == eeh_pkg::CL_TX) begin
                  shreg_d = {shreg_q[6:0], 1'b0};
               end
            end
         end else begin
            qcnt_d = qcnt_q + eeh_pkg::QCNT_W'(1);
         end
      end
      unique case (state_q)
         ST_IDLE: if (cmd_valid) begin
            op_d    = eeh_pkg::eeh_op_t'(cmd_op);
            chip_d  = cmd_chip;
            addr_d  = cmd_addr;
            left_d  = cmd_len;                           // At most one page
            err_d   = 1'b0;
            pend_d  = 1'b0;
            state_d = ST_START;                          // Every command opens with start
         end
         ST_START: if (sym_done) begin
            if (op_q == eeh_pkg::OP_REC) begin
               state_d = ST_CLK9;                        // Nine free clocks
            end else if (op_q == eeh_pkg::OP_CUR) begin
               shreg_d = {eeh_pkg::DEV_ID, chip_q, 1'b1};  // Read at counter
               state_d = ST_RDEV;
            end else begin
               shreg_d = {eeh_pkg::DEV_ID, chip_q, 1'b0};  // Write word first
               state_d = ST_DEV;
            end
         end
         ST_CLK9: if (sym_done) state_d = ST_RSTART;
         ST_RSTART: if (sym_done) begin
            if (op_q == eeh_pkg::OP_REC) begin
               state_d = ST_STOP;                        // Start then stop ends recovery
            end else begin
               shreg_d = {eeh_pkg::DEV_ID, chip_q, 1'b1};  // Repeated start, read
               state_d = ST_RDEV;
            end
         end
         ST_DEV, ST_AHI, ST_ALO, ST_RDEV: if (sym_done) begin
            if (!ack_q) begin
               err_d   = 1'b1;                           // No answer, give up with stop
               state_d = ST_STOP;
            end else if (state_q == ST_DEV) begin
               shreg_d = {1'b0, addr_q[14:8]};           // High address byte
               state_d = ST_AHI;
            end else if (state_q == ST_AHI) begin
               shreg_d = addr_q[7:0];
               state_d = ST_ALO;
            end else if (state_q == ST_ALO) begin
               state_d = (op_q == eeh_pkg::OP_WRITE) ? ST_WWAIT : ST_RSTART;
            end else begin
               state_d = ST_RDATA;
            end
         end
         // Clock held low while the buffer is empty; the bus simply pauses
         ST_WWAIT: if (fifo_valid) begin
            fifo_pop = 1'b1;
            shreg_d  = fifo_data;
            state_d  = ST_WDATA;
         end
         ST_WDATA: if (sym_done) begin
            if (!ack_q) begin
               err_d   = 1'b1;
               state_d = ST_STOP;
            end else if (left_q == 6'h0) begin
               pend_d  = 1'b1;                           // Stop starts the program cycle
               state_d = ST_STOP;
            end else begin
               left_d  = left_q - 6'h1;                  // More bytes of the page
               state_d = ST_WWAIT;
            end
         end
         ST_RDATA: if (sym_done) begin
            rdv_d = 1'b1;
            rd_d  = shreg_q;
            if (left_q == 6'h0) begin
               state_d = ST_STOP;                        // No-ack then stop
            end else begin
               left_d = left_q - 6'h1;
            end
         end
         ST_STOP: if (sym_done) begin
            if (pend_q) begin
               pend_d  = 1'b0;
               state_d = ST_PSTART;                      // Poll the program cycle
            end else begin
               done_d  = 1'b1;
               state_d = ST_IDLE;
            end
         end
         ST_PSTART: if (sym_done) begin
            shreg_d = {eeh_pkg::DEV_ID, chip_q, 1'b0};
            state_d = ST_PDEV;
         end
         ST_PDEV: if (sym_done) begin
            if (ack_q) begin
               state_d = ST_STOP;                        // Program cycle finished
            end else if (poll_q >= 24'(PROG_CYC)) begin
               err_d   = 1'b1;                           // Longer than the program time
               state_d = ST_STOP;
            end else begin
               state_d = ST_PSTART;
            end
         end
      endcase
      cmd_ready_d = (state_d == ST_IDLE);
   end

   // Two flops on SDA before anything looks at it
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         sda_m_q <= sda_in;
         sda_s_q <= sda_m_q;
      end
   end

   // State and output registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         op_q    <= eeh_pkg::OP_WRITE;
         chip_q  <= '0;
         addr_q  <= '0;
         left_q  <= '0;
         shreg_q <= '0;
         qcnt_q  <= '0;
         ph_q    <= '0;
         bit_q   <= '0;
         ack_q   <= 1'b0;
         pend_q  <= 1'b0;
         poll_q  <= '0;
         err_q   <= 1'b0;
         scl       <= 1'b1;
         sda_oe    <= 1'b0;
         sda_out   <= 1'b0;
         cmd_ready <= 1'b0;
         done      <= 1'b0;
         rd_valid  <= 1'b0;
         rd_data   <= '0;
      end else begin
         state_q <= state_d;
         op_q    <= op_d;
         chip_q  <= chip_d;
         addr_q  <= addr_d;
         left_q  <= left_d;
         shreg_q <= shreg_d;
         qcnt_q  <= qcnt_d;
         ph_q    <= ph_d;
         bit_q   <= bit_d;
         ack_q   <= ack_d;
         pend_q  <= pend_d;
         poll_q  <= poll_d;
         err_q   <= err_d;
         scl       <= scl_d;
         sda_oe    <= sda_oe_d;
         sda_out   <= 1'b0;
         cmd_ready <= cmd_ready_d;
         done      <= done_d;
         rd_valid  <= rdv_d;
         rd_data   <= rd_d;
      end
   end
   assign err = err_q;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   start_edge_a: assert property ($rose(sda_oe) && scl |-> $past(cls) == eeh_pkg::CL_START)
      else $error("SDA fell under high SCL outside a start");
   stop_edge_a: assert property ($fell(sda_oe) && scl |-> $past(cls) == eeh_pkg::CL_STOP)
      else $error("SDA rose under high SCL outside a stop");
   data_stable_a: assert property ($changed(sda_oe) && $past(cls, 2) inside {eeh_pkg::CL_TX,
      eeh_pkg::CL_RX} && $past(cls) == $past(cls, 2) |-> !scl)
      else $error("Data bit changed while SCL high");
   ack_release_a: assert property ($past(cls) == eeh_pkg::CL_TX
      && $past(bit_q) == eeh_pkg::BIT_LAST |-> !sda_oe)
      else $error("Host drove SDA in the acknowledge clock");
   id_pattern_a: assert property ($changed(state_q) && state_q inside {ST_DEV, ST_RDEV, ST_PDEV}
      |-> shreg_q[7:4] == eeh_pkg::DEV_ID && shreg_q[3:1] == chip_q)
      else $error("Device word has a wrong head");
   read_dir_a: assert property ($changed(state_q) && state_q == ST_RDEV |-> shreg_q[0])
      else $error("Read device word without read bit");
   rx_ack_a: assert property ($past(cls) == eeh_pkg::CL_RX && $past(bit_q) == eeh_pkg::BIT_LAST
      |-> sda_oe == ($past(left_q) != 6'h0))
      else $error("Wrong host acknowledge after read byte");
   recover_a: assert property (state_q == ST_CLK9 && sym_done |=> state_q == ST_RSTART ##0
      (state_q == ST_RSTART)[*2])
      else $error("Recovery clocks not followed by start");
   write_stop_a: assert property (sym_done && state_q == ST_WDATA && ack_q && left_q == 6'h0
      |=> state_q == ST_STOP && pend_q)
      else $error("Last write byte not closed by a stop");
   poll_after_a: assert property (sym_done && state_q == ST_STOP && pend_q
      |=> state_q == ST_PSTART ##1 state_q == ST_PSTART)
      else $error("No polling after write stop");

   write_c: cover property (sym_done && state_q == ST_STOP && pend_q);
   read_c: cover property (rd_valid ##1 !rd_valid);
   poll_c: cover property (sym_done && state_q == ST_PDEV && !ack_q);
   rec_c: cover property (state_q == ST_CLK9 && sym_done);
endmodule

// *** rtl/eeh_pkg.sv ***
// Package for the two-wire serial memory host controller.
// Assumes a 100 MHz system clock; the host makes the serial clock itself.
package eeh_pkg;

   // ==========================================================
   // Clock and bus timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 10;      // System clock period
   localparam int SCL_PERIOD_NS = 2500;    // Serial clock period, 400 kHz
   // Each serial bit is four quarters; a least time, so round up
   localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam int QCNT_W  = 7;             // Width of the quarter counter
   localparam int PROG_TIME_MS = 5;        // Longest internal program time
   // Cycles of internal program time; a longest time, so round down
   localparam int PROG_CYC = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;

   // ==========================================================
   // Word layout
   // ==========================================================
   localparam logic [3:0] DEV_ID   = 4'hA;  // Fixed top nibble of the device word
   localparam logic [3:0] BIT_LAST = 4'h8;  // Ninth clock carries the acknowledge
   localparam int DATA_W     = 8;           // Byte width
   localparam int FIFO_DEPTH = 16;          // Write data buffer depth
   localparam int ADDR_W     = 15;          // Word address width
   localparam int LEN_W      = 6;           // Byte count minus one, up to one page

   // ==========================================================
   // Commands and bit symbols
   // ==========================================================
   typedef enum logic [1:0] {
      OP_WRITE,                             // Byte or page write, then polling
      OP_RAND,                              // Random read, sequential if longer
      OP_CUR,                               // Current address read
      OP_REC                                // Bus recovery sequence
   } eeh_op_t;

   typedef enum logic [2:0] {
      CL_NONE, CL_START, CL_STOP, CL_TX, CL_RX, CL_CLK
   } eeh_cls_t;

endpackage

// *** tb/eeh_mem_model.sv ***
// Behavioural two-wire serial memory standing on the far side of the host.
// Assumes the bench resolves SDA as a pulled-up wire from both enables.
`timescale 1ns/10ps
module eeh_mem_model #(
   parameter logic [2:0] STRAPS  = 3'h5,  // Strapped chip select value
   parameter int         BUSY_NS = 8000   // Shortened program time; first poll misses
) (
   input  wire logic scl,                 // Serial clock from host
   input  wire logic sda,                 // Resolved data line
   input  wire logic wp,                  // Write protect level
   output logic      dev_oe               // Pulls SDA low when high
);
   logic [7:0]  mem [32768];              // 512 pages of 64 bytes
   logic [14:0] ptr;                      // Address counter
   logic [7:0]  b;                        // Received word
   logic        more;                     // Host asked for another byte
   logic        busy;                      // Program cycle running
   logic        pend;                      // Stored data awaits stop
   int          nst;                       // Starts seen
   int          seen;                      // Starts handled
   // ==========================================================
   // Bus behaviour
   // ==========================================================
   // Standby at power-up, array preset to a known pattern
   initial begin
      dev_oe = 1'b0;
      busy = 1'b0;
      pend = 1'b0;
      ptr = '0;
      nst = 0;
      seen = 0;
      for (int i = 0; i < 32768; i++) mem[i] = 8'(i) ^ 8'h5A;
   end
   // SDA falling with SCL high restarts the sequence
   always @(negedge sda) if (scl === 1'b1) begin
      nst++;
      disable xfer;
   end
   // Stop ends the sequence; a pending write starts programming
   always @(posedge sda) if (scl === 1'b1) begin
      disable xfer;
      dev_oe = 1'b0;
      if (pend) begin
         pend = 1'b0;
         busy = 1'b1;
         #BUSY_NS busy = 1'b0;
      end
   end
   // Words arrive MSB first, sampled on rising SCL
   task automatic rx(output logic [7:0] v);
      repeat (8) begin
         @(posedge scl);
         v = {v[6:0], sda};
      end
   endtask
   // Low in the ninth clock, released after its falling edge
   task automatic ack();
      @(negedge scl);
      dev_oe = 1'b1;
      @(negedge scl);
      dev_oe = 1'b0;
   endtask
   // Bits change only after falling SCL
   task automatic tx(input logic [7:0] v, output logic m);
      for (int i = 7; i >= 0; i--) begin
         dev_oe = !v[i];
         @(negedge scl);
      end
      dev_oe = 1'b0;
      @(posedge scl);
      m = !sda;
      @(negedge scl);
   endtask
   // Wrong word or busy array: no answer at all
   always begin : xfer
      wait (nst != seen);
      seen = nst;
      dev_oe = 1'b0;
      rx(b);
      if (b[7:1] == {4'hA, STRAPS} && !busy) begin
         ack();
         if (b[0]) begin
            // Read: counter rolls over at the top of the array
            do begin
               tx(mem[ptr], more);
               ptr = ptr + 15'h1;
            end while (more);
         end else begin
            // Write: two address bytes, then data wrapping in its page
            rx(b);
            ack();
            ptr[14:8] = b[6:0];
            rx(b);
            ack();
            ptr[7:0] = b;
            forever begin
               rx(b);
               ack();
               // Protected writes are acknowledged but not stored
               if (wp !== 1'b1) begin
                  mem[ptr] = b;
                  pend = 1'b1;
               end
               ptr[5:0] = ptr[5:0] + 6'h1;
            end
         end
      end
   end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench: host controller against the memory model.
// Assumes the model answers on straps 5; SDA is a pulled-up wire.
`timescale 1ns/10ps
module tb_top;
   typedef struct packed {
      logic [1:0] op;    // 0 write, 1 random, 2 current, 3 recovery
      logic [2:0] chip;
      logic [14:0] addr;
      logic [5:0] len;
      logic [7:0] seed;
      logic wp;
      logic err;
   } eeh_row_t;
   logic        clock, sys_rst, cmd_valid, cmd_ready, wr_valid, wr_ready;
   logic        rd_valid, done, err, scl, sda_out, sda_oe, dev_oe, wp;
   logic [1:0]  cmd_op;
   logic [2:0]  cmd_chip;
   logic [14:0] cmd_addr, eptr;
   logic [5:0]  cmd_len;
   logic [7:0]  wr_data, rd_data, emem [32768];
   logic [7:0]  got [$];
   int          n_fail, total_checks;
   wire         sda = !(sda_oe | dev_oe);
   // Ordinary cases: each row gives stimulus and expected error
   localparam eeh_row_t ROWS [9] = '{
      '{2'h0, 3'h5, 15'h0010, 6'h00, 8'h11, 0, 0}, '{2'h0, 3'h5, 15'h007E, 6'h03, 8'h20, 0, 0},
      '{2'h1, 3'h5, 15'h007E, 6'h03, 0, 0, 0}, '{2'h2, 3'h5, 0, 6'h00, 0, 0, 0},
      '{2'h0, 3'h5, 15'h0010, 6'h00, 8'h99, 1, 0}, '{2'h1, 3'h5, 15'h0010, 6'h00, 0, 0, 0},
      '{2'h0, 3'h2, 15'h0010, 6'h00, 0, 0, 1}, '{2'h3, 3'h5, 0, 0, 0, 0, 0},
      '{2'h1, 3'h5, 15'h7FFF, 6'h01, 0, 0, 0}};
   eeh_ctrl #(.PROG_CYC(20000), .QTR_CYC(16)) dut_u (.clock(clock), .sys_rst(sys_rst),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_chip(cmd_chip),
      .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_data(wr_data),
      .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .err(err),
      .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe), .sda_in(sda));
   eeh_mem_model #(.STRAPS(3'h5)) mem_u (.scl(scl), .sda(sda), .wp(wp), .dev_oe(dev_oe));
   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Bounded wait on 0 cmd_ready, 1 done, 2 wr_ready; a timeout ends the run
   task automatic wait_hi(input int w, input int lim);
      logic s;
      s = 1'b0;
      for (int k = 0; k < lim && s !== 1'b1; k++) begin
         @(posedge clock);
         s = (w == 0) ? cmd_ready : (w == 1) ? done : wr_ready;
      end
      chk("wait", 16'(s), 16'h1);
      if (s !== 1'b1) give_verdict();
   endtask
   task automatic push(input logic [7:0] v, input logic [5:0] n);
      for (int i = 0; i <= n; i++) begin
         wr_valid <= 1'b1;
         wr_data <= v + 8'(i);
         wait_hi(2, 100);
      end
      wr_valid <= 1'b0;
   endtask
   // One command, then expectations kept in a shadow array
   task automatic run(input eeh_row_t r, input bit pre);
      logic [14:0] a;
      a = (r.op == 2'h2) ? eptr : r.addr;
      wp <= r.wp;
      got.delete();
      if (r.op == 2'h0 && !r.err && !pre) push(r.seed, r.len);
      cmd_valid <= 1'b1;
      cmd_op <= r.op;
      cmd_chip <= r.chip;
      cmd_addr <= r.addr;
      cmd_len <= r.len;
      wait_hi(0, 10);
      cmd_valid <= 1'b0;
      wait_hi(1, 60000);
      chk("err", 16'(err), 16'(r.err));
      if (r.op == 2'h0 && !r.err) begin
         for (int i = 0; i <= r.len; i++)
            if (!r.wp) emem[{a[14:6], 6'(a[5:0] + i)}] = r.seed + 8'(i);
         eptr = {a[14:6], 6'(a[5:0] + r.len + 1)};
      end
      if (r.op == 2'h1 || r.op == 2'h2) begin
         chk("count", 16'(got.size()), 16'(r.len) + 16'h1);
         foreach (got[i])
            chk("rd_data", 16'(got[i]), 16'(emem[15'(a + i)]));
         eptr = 15'(a + r.len + 1);
      end
   endtask
   // ==========================================================
   // Clock, monitor and sequence
   // ==========================================================
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) if (rd_valid === 1'b1) got.push_back(rd_data);
   initial begin
      {sys_rst, cmd_valid, wr_valid, wp, cmd_op, cmd_chip, cmd_addr, cmd_len, wr_data} = 1'b1 << 37;
      {n_fail, total_checks, eptr} = '0;
      for (int i = 0; i < 32768; i++) emem[i] = 8'(i) ^ 8'h5A;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clock);
      chk("idle", {scl, sda_oe, sda_out, cmd_ready, wr_ready, done}, 16'h0026);
      foreach (ROWS[i]) run(ROWS[i], 1'b0);
      // Fill the buffer until it refuses, then drain it with one page write
      push(8'h40, 6'h0F);
      @(posedge clock);
      chk("wr_ready", 16'(wr_ready), 16'h0);
      run('{2'h0, 3'h5, 15'h0100, 6'h0F, 8'h40, 0, 0}, 1'b1);
      run('{2'h1, 3'h5, 15'h010E, 6'h01, 0, 0, 0}, 1'b0);
      give_verdict();
   end
endmodule
